// *** acc_pkg.sv ***
// constants and carrier types for the converter control block
// What this block does and what software must do
// R1: low enable bit n makes port A pin n analog
// R2: high enable bits 3..0 enable channels 11..8
// R3: high enable bits 7..4 read zero
// R4: start pulse 0-1-0 begins a conversion
// R5: start held high resets core, busy forced
// R6: busy clears automatically at conversion end
// R7: completion sets request flag, gated by enable
// R8: software may poll busy flag instead
// R9: divider codes 0..6 divide by 2**code
// R10: software keeps converter clock period >= 0.5us
// R11: power-off bit high switches converter off
// R12: software waits settling after power-on
// R13: software powers converter off when unused
// R14: reference select picks supply or external pin
// R15: analog enable overrides pin function, pull, direction
// R16: conversion lasts sixteen converter clock periods
// R17: result is twelve bits, full scale all ones
// R18: busy stays high through active conversion
package acc_pkg;
    // register byte addresses
    localparam logic [3:0] ADDR_CH_LOW  = 4'h0;
    localparam logic [3:0] ADDR_CH_HIGH = 4'h4;
    localparam logic [3:0] ADDR_CTRL0   = 4'h8;
    localparam logic [3:0] ADDR_CTRL1   = 4'hc;
    // control zero fields
    localparam int CTRL0_START = 7;
    localparam int CTRL0_BUSY  = 6;
    localparam int CTRL0_OFF   = 5;
    localparam int CTRL0_IRQF  = 4;
    localparam int CTRL0_IEN   = 3;
    // control one fields
    localparam int CTRL1_REF   = 4;
    localparam int CTRL1_DIV_LO = 0;
    // reset values and full-scale code
    localparam logic [7:0]  CH_LOW_RST  = 8'hff;
    localparam logic [3:0]  CH_HIGH_RST = 4'hf;
    localparam logic [2:0]  DIV_RST     = 3'h0;
    localparam logic        OFF_RST     = 1'b1;
    localparam logic [11:0] FULL_SCALE  = 12'hfff;
    // timing
    localparam int          CONV_PERIODS = 16;
    localparam logic [2:0]  DIV_UNDEF    = 3'h7;

    typedef enum logic [1:0] {ST_IDLE, ST_RESET, ST_CONV} acc_state_e;

    // pin-side controls for all twelve analog-capable pins
    typedef struct packed {
        logic [11:0] analog_en;
        logic [11:0] pull_dis;
        logic [11:0] dir_ovr;
        logic        vref_pin_sel;
        logic        vref_func_dis;
    } acc_pin_s;

    // controls toward the analog core
    typedef struct packed {
        logic        power_off;
        logic        core_reset;
        logic        sample_clk;
        logic        finish;
    } acc_core_s;
endpackage

// *** acc_top.sv ***
// converter channel enable, start handshake, divider and status logic
`timescale 1ns/1ps
module acc_top (
    input  wire logic             core_clk,
    input  wire logic             rstn,
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [3:0]       wb_adr_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic [31:0]      wb_dat_i,
    output logic      [31:0]      wb_dat_o,
    output logic                  wb_ack_o,
    input  wire logic [11:0]      core_result,
    output acc_pkg::acc_pin_s     pin_ctrl,
    output acc_pkg::acc_core_s    core_ctrl,
    output logic      [11:0]      result_data,
    output logic                  irq_req
);
    ////////////////////////////////////////////////////////////////////////////
    // registers
    logic [7:0]  ch_low_r,  ch_low_nxt;
    logic [3:0]  ch_high_r, ch_high_nxt;
    logic        start_r,   start_nxt;
    logic        busy_r,    busy_nxt;
    logic        off_r,     off_nxt;
    logic        irqf_r,    irqf_nxt;
    logic        ien_r,     ien_nxt;
    logic        ref_r,     ref_nxt;
    logic [2:0]  div_r,     div_nxt;
    logic        ack_r,     ack_nxt;
    logic [31:0] rdat_r,    rdat_nxt;
    logic [11:0] res_r,     res_nxt;
    logic [6:0]  pre_r,     pre_nxt;
    logic        tick_r,    tick_nxt;
    logic [4:0]  cnt_r,     cnt_nxt;
    acc_pkg::acc_state_e st_r, st_nxt;

    logic        wr_en;
    logic        rd_en;
    logic        done;
    logic [6:0]  div_mask;
    logic [7:0]  ctrl0_rd;
    logic [7:0]  ctrl1_rd;

    // a transfer is taken once; ack drops in the cycle after it was given
    assign wr_en = wb_cyc_i & wb_stb_i & ~ack_r & wb_we_i & wb_sel_i[0];
    assign rd_en = wb_cyc_i & wb_stb_i & ~ack_r;

    assign ctrl0_rd = {start_r, busy_r, off_r, irqf_r, ien_r, 3'h0};
    assign ctrl1_rd = {3'h0, ref_r, 1'b0, div_r};

    // R9 divide by 2**code; code 7 is undefined, held as divide by 1
    assign div_mask = (div_r == acc_pkg::DIV_UNDEF) ? 7'h00
                                                    : 7'((8'h01 << div_r) - 8'h01);
    assign done = (st_r == acc_pkg::ST_CONV) && tick_r
                  && (cnt_r == 5'(acc_pkg::CONV_PERIODS - 1));

    ////////////////////////////////////////////////////////////////////////////
    // bus and register next state
    always_comb begin
        ch_low_nxt  = ch_low_r;
        ch_high_nxt = ch_high_r;
        start_nxt   = start_r;
        off_nxt     = off_r;
        ien_nxt     = ien_r;
        ref_nxt     = ref_r;
        div_nxt     = div_r;
        irqf_nxt    = irqf_r;
        ack_nxt     = rd_en;
        rdat_nxt    = rdat_r;
        if (wr_en) begin
            // R1 per-pin enables, low register
            if (wb_adr_i == acc_pkg::ADDR_CH_LOW) begin
                ch_low_nxt = wb_dat_i[7:0];
            end else if (wb_adr_i == acc_pkg::ADDR_CH_HIGH) begin
                // R2 high enables stored in four bits
                ch_high_nxt = wb_dat_i[3:0];
            end else if (wb_adr_i == acc_pkg::ADDR_CTRL0) begin
                start_nxt = wb_dat_i[acc_pkg::CTRL0_START];
                off_nxt   = wb_dat_i[acc_pkg::CTRL0_OFF];
                ien_nxt   = wb_dat_i[acc_pkg::CTRL0_IEN];
                if (!wb_dat_i[acc_pkg::CTRL0_IRQF]) begin
                    irqf_nxt = 1'b0;
                end
            end else if (wb_adr_i == acc_pkg::ADDR_CTRL1) begin
                ref_nxt = wb_dat_i[acc_pkg::CTRL1_REF];
                div_nxt = wb_dat_i[acc_pkg::CTRL1_DIV_LO +: 3];
            end
        end
        // R7 completion sets the flag; set wins over a clear
        if (done) begin
            irqf_nxt = 1'b1;
        end
        if (rd_en) begin
            // R3 upper high bits read zero; unmapped reads zero
            if (wb_adr_i == acc_pkg::ADDR_CH_LOW) begin
                rdat_nxt = {24'h0, ch_low_r};
            end else if (wb_adr_i == acc_pkg::ADDR_CH_HIGH) begin
                rdat_nxt = {28'h0, ch_high_r};
            end else if (wb_adr_i == acc_pkg::ADDR_CTRL0) begin
                rdat_nxt = {24'h0, ctrl0_rd};
            end else if (wb_adr_i == acc_pkg::ADDR_CTRL1) begin
                rdat_nxt = {24'h0, ctrl1_rd};
            end else begin
                rdat_nxt = 32'h0;
            end
        end
    end

    // register update
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            ch_low_r  <= acc_pkg::CH_LOW_RST;
            ch_high_r <= acc_pkg::CH_HIGH_RST;
            start_r   <= 1'b0;
            off_r     <= acc_pkg::OFF_RST;
            ien_r     <= 1'b0;
            ref_r     <= 1'b0;
            div_r     <= acc_pkg::DIV_RST;
            irqf_r    <= 1'b0;
            ack_r     <= 1'b0;
            rdat_r    <= 32'h0;
        end else begin
            ch_low_r  <= ch_low_nxt;
            ch_high_r <= ch_high_nxt;
            start_r   <= start_nxt;
            off_r     <= off_nxt;
            ien_r     <= ien_nxt;
            ref_r     <= ref_nxt;
            div_r     <= div_nxt;
            irqf_r    <= irqf_nxt;
            ack_r     <= ack_nxt;
            rdat_r    <= rdat_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // converter clock prescaler: one tick per divided period
    always_comb begin
        pre_nxt  = pre_r + 7'h01;
        tick_nxt = 1'b0;
        // restart the prescaler at conversion start so periods are whole
        // no tick after the last period: the core must see exactly sixteen
        if (st_r != acc_pkg::ST_CONV || done) begin
            pre_nxt = 7'h00;
        end else if ((pre_r & div_mask) == div_mask) begin
            pre_nxt  = 7'h00;
            tick_nxt = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            pre_r  <= 7'h00;
            tick_r <= 1'b0;
        end else begin
            pre_r  <= pre_nxt;
            tick_r <= tick_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // start handshake and conversion sequencer
    always_comb begin
        st_nxt   = st_r;
        cnt_nxt  = cnt_r;
        busy_nxt = busy_r;
        res_nxt  = res_r;
        case (st_r)
            acc_pkg::ST_IDLE: begin
                if (start_r) begin
                    st_nxt   = acc_pkg::ST_RESET;
                    busy_nxt = 1'b1;
                end
            end
            acc_pkg::ST_RESET: begin
                // R5 core held in reset, busy forced while start high
                busy_nxt = 1'b1;
                cnt_nxt  = 5'h00;
                // R4 falling edge completes the pulse, conversion begins
                if (!start_r) begin
                    st_nxt = acc_pkg::ST_CONV;
                end
            end
            acc_pkg::ST_CONV: begin
                // R18 busy held through the conversion
                busy_nxt = 1'b1;
                if (start_r) begin
                    st_nxt = acc_pkg::ST_RESET;
                end else if (done) begin
                    // R6 busy clears itself; R17 twelve-bit result
                    st_nxt   = acc_pkg::ST_IDLE;
                    busy_nxt = 1'b0;
                    res_nxt  = core_result & acc_pkg::FULL_SCALE;
                end else if (tick_r) begin
                    // R16 count sixteen converter clock periods
                    cnt_nxt = cnt_r + 5'h01;
                end
            end
            default: begin
                st_nxt = acc_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            st_r   <= acc_pkg::ST_IDLE;
            cnt_r  <= 5'h00;
            busy_r <= 1'b0;
            res_r  <= 12'h000;
        end else begin
            st_r   <= st_nxt;
            cnt_r  <= cnt_nxt;
            busy_r <= busy_nxt;
            res_r  <= res_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign wb_ack_o    = ack_r;
    assign wb_dat_o    = rdat_r;
    assign result_data = res_r;
    // R7 request raised only while enabled
    assign irq_req     = irqf_r & ien_r;

    // R15 analog enable overrides pin function, pull-high, direction
    assign pin_ctrl.analog_en = {ch_high_r, ch_low_r};
    assign pin_ctrl.pull_dis  = {ch_high_r, ch_low_r};
    assign pin_ctrl.dir_ovr   = {ch_high_r, ch_low_r};
    // R14 external reference pin takes over its shared functions
    assign pin_ctrl.vref_pin_sel  = ref_r;
    assign pin_ctrl.vref_func_dis = ref_r;

    // R11 power-off bit high switches converter off
    assign core_ctrl.power_off  = off_r;
    assign core_ctrl.core_reset = (st_r == acc_pkg::ST_RESET);
    assign core_ctrl.sample_clk = tick_r;
    assign core_ctrl.finish     = done;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_pulse_end;
        (st_r == acc_pkg::ST_RESET) ##1 !start_r;
    endsequence

    // check helpers: time spent converting and whether the divider moved
    logic [10:0] conv_age_r,  conv_age_nxt;
    logic        div_moved_r, div_moved_nxt;
    logic [10:0] conv_expect;

    // sixteen converter periods of 2**code system clocks each
    assign conv_expect = 11'(acc_pkg::CONV_PERIODS) << div_r;

    // age saturates so a stalled conversion never wraps to a small count
    always_comb begin
        conv_age_nxt  = 11'h000;
        div_moved_nxt = 1'b0;
        if (st_r == acc_pkg::ST_CONV) begin
            conv_age_nxt  = (conv_age_r == 11'h7ff) ? conv_age_r : conv_age_r + 11'h001;
            div_moved_nxt = div_moved_r | (div_nxt != div_r);
        end
    end

    // helper registers, cleared outside a conversion
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            conv_age_r  <= 11'h000;
            div_moved_r <= 1'b0;
        end else begin
            conv_age_r  <= conv_age_nxt;
            div_moved_r <= div_moved_nxt;
        end
    end

    // R5 reset state forces busy and core reset
    a_reset_forces_busy: assert property (@(posedge core_clk) disable iff (!rstn) // R5
        (st_r == acc_pkg::ST_RESET) |-> busy_r && core_ctrl.core_reset)
        else $error("busy or core reset low while start held");
    // R5 raised start resets core next cycle
    a_start_sets_busy: assert property (@(posedge core_clk) disable iff (!rstn) // R5
        start_r |=> busy_r && core_ctrl.core_reset)
        else $error("start high did not force busy and core reset");
    // R4 falling start leads to conversion
    a_pulse_starts_conv: assert property (@(posedge core_clk) disable iff (!rstn) // R4
        s_pulse_end |=> (st_r == acc_pkg::ST_CONV))
        else $error("start pulse did not begin conversion");
    // R6 busy falls right after completion
    a_done_clears_busy: assert property (@(posedge core_clk) disable iff (!rstn) // R6
        done && !start_r |=> !busy_r)
        else $error("busy not cleared at completion");
    // R7 completion sets the request flag
    a_done_sets_flag: assert property (@(posedge core_clk) disable iff (!rstn) // R7
        done |=> irqf_r)
        else $error("request flag not set at completion");
    // R7 interrupt never raised while disabled
    a_irq_gated: assert property (@(posedge core_clk) disable iff (!rstn) // R7
        !ien_r |-> !irq_req)
        else $error("interrupt raised while disabled");
    // R18 busy stays high while converting
    a_busy_in_conv: assert property (@(posedge core_clk) disable iff (!rstn) // R18
        (st_r == acc_pkg::ST_CONV) |-> busy_r)
        else $error("busy low during conversion");
    // R16 completion exactly sixteen periods in, for any defined code
    a_conv_length: assert property (@(posedge core_clk) disable iff (!rstn) // R16 R9
        (st_r == acc_pkg::ST_CONV) && (div_r != acc_pkg::DIV_UNDEF) && !div_moved_r
        |-> done == (conv_age_r == conv_expect))
        else $error("conversion length wrong");
    // R3 upper high bits read zero
    a_high_read_zero: assert property (@(posedge core_clk) disable iff (!rstn) // R3
        rd_en && wb_adr_i == acc_pkg::ADDR_CH_HIGH |=> wb_dat_o[31:4] == 28'h0)
        else $error("high enable upper bits not zero");
    // R1 pin enables mirror the low register
    a_pin_follows_reg: assert property (@(posedge core_clk) disable iff (!rstn) // R1
        wr_en && wb_adr_i == acc_pkg::ADDR_CH_LOW
        |=> pin_ctrl.analog_en[7:0] == $past(wb_dat_i[7:0]))
        else $error("pin enables do not follow write");
endmodule

// *** acc_core_model.sv ***
// behavioural analog core that hands conversion codes back to the block
`timescale 1ns/1ps
module acc_core_model (
    input  wire logic               core_clk,
    input  wire acc_pkg::acc_core_s core_ctrl,
    input  wire logic [11:0]        next_val,
    output logic      [11:0]        core_result
);
    logic [11:0] junk_r = 12'ha5a;

    ////////////////////////////////////////////////////////////////////////
    // a powered-down core gives no valid code, so the pattern keeps moving
    always_ff @(posedge core_clk) begin
        junk_r <= ~junk_r ^ 12'h5a5;
    end

    assign core_result = core_ctrl.power_off ? junk_r : next_val;
endmodule

// *** tb_acc_top.sv ***
// self-checking bench for the converter control block
`timescale 1ns/1ps
module tb_acc_top;
    logic               core_clk, rstn, cyc, stb, we, cnt_on;
    logic [3:0]         adr, sel;
    logic [31:0]        dat_i, dat_o;
    logic               ack, irq_req;
    logic [11:0]        core_result, next_val, result_data;
    logic [7:0]         q, v;
    logic [7:0]         mdl [4];
    logic [7:0]         msk [4] = '{8'hff, 8'h0f, 8'hff, 8'h17};
    acc_pkg::acc_pin_s  pin_ctrl;
    acc_pkg::acc_core_s core_ctrl;
    int                 mismatches, checked, ticks, k;

    acc_top acc_top_i (.core_clk(core_clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_i), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .core_result(core_result), .pin_ctrl(pin_ctrl),
        .core_ctrl(core_ctrl), .result_data(result_data), .irq_req(irq_req));

    acc_core_model acc_core_model_i (.core_clk(core_clk), .core_ctrl(core_ctrl),
        .next_val(next_val), .core_result(core_result));

    ////////////////////////////////////////////////////////////////////////
    // clock, 40 ns period
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    // count converter clock ticks of one conversion, stop at its end
    always @(posedge core_clk) begin
        if (cnt_on) begin
            if (core_ctrl.sample_clk === 1'b1) ticks++;
            if (core_ctrl.finish === 1'b1) cnt_on = 1'b0;
        end
    end

    task stop_test();
        if (mismatches == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one classic cycle; held until ack is sampled, model follows writes
    task wb(input logic w, input logic [3:0] a, input logic [7:0] d, input logic [3:0] s);
        @(posedge core_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        dat_i <= {24'h0, d};
        // a missing answer is left to the watchdog, which fails the run
        do begin
            @(posedge core_clk);
        end while (ack !== 1'b1);
        q = dat_o[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        if (w && s[0] && a[1:0] == 2'b00) mdl[a[3:2]] = d & msk[a[3:2]];
    endtask

    // the watchdog cuts a hang well past the expected run length
    initial begin
        #2000000;
        mismatches++;
        stop_test();
    end

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        {rstn, cyc, stb, we, adr, sel, dat_i, cnt_on, next_val} = '0;
        mismatches = 0;
        checked = 0;
        ticks = 0;
        mdl = '{8'hff, 8'h0f, 8'h20, 8'h00};
        void'($urandom(47));
        repeat (4) @(posedge core_clk);
        rstn <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            wb(1'b0, 4'(4 * i), 8'h00, 4'hf);
            chk(q, mdl[i]);
        end
        chk(pin_ctrl.analog_en, 12'hfff);
        v = 8'($urandom);
        wb(1'b1, 4'h0, v, 4'hf);
        wb(1'b1, 4'h4, ~v, 4'hf);
        wb(1'b1, 4'h0, ~v, 4'h0);
        wb(1'b0, 4'h0, 8'h00, 4'hf);
        chk(q, mdl[0]);
        wb(1'b0, 4'h4, 8'h00, 4'hf);
        chk(q, mdl[1]);
        chk(pin_ctrl[37:14], {2{mdl[1][3:0], mdl[0]}});
        chk(pin_ctrl[13:0], {mdl[1][3:0], mdl[0], 2'b00});
        wb(1'b0, 4'h2, 8'h00, 4'hf);
        chk(q, 8'h00);
        for (int r = 0; r < 2; r++) begin
            wb(1'b1, 4'hc, {3'h0, r[0], 4'h0}, 4'hf);
            chk({pin_ctrl.vref_pin_sel, pin_ctrl.vref_func_dis}, {2{r[0]}});
        end
        wb(1'b1, 4'h8, 8'h08, 4'hf);
        chk(core_ctrl.power_off, 1'b0);
        // settling time after power-up before any start
        repeat (8) @(posedge core_clk);
        // codes below 4 break the period floor; model stays exact
        for (int d = 0; d < 7; d++) begin
            wb(1'b1, 4'hc, 8'(d), 4'hf);
            next_val <= (d == 6) ? acc_pkg::FULL_SCALE : 12'($urandom);
            v = (d == 3) ? 8'h80 : 8'h88;
            wb(1'b1, 4'h8, v, 4'hf);
            wb(1'b0, 4'h8, 8'h00, 4'hf);
            chk(q[6], 1'b1);
            chk(core_ctrl.core_reset, 1'b1);
            ticks = 0;
            wb(1'b1, 4'h8, v & 8'h7f, 4'hf);
            cnt_on = 1'b1;
            k = 0;
            do begin
                wb(1'b0, 4'h8, 8'h00, 4'hf);
                k++;
            end while (q[6] === 1'b1 && k < 400);
            chk(ticks, 16);
            chk({q[6], q[4]}, 2'b01);
            chk(irq_req, d != 3);
            chk(result_data, next_val);
        end
        wb(1'b1, 4'h8, 8'h28, 4'hf);
        chk({irq_req, core_ctrl.power_off}, 2'b01);
        stop_test();
    end
endmodule
